// File: rtl/flash_bus_if.sv
/*
 * Flash bus between host sequencer and device command decoder.
 * Assumes one shared clock; active-low strobes as on the flash pins.
 */
`default_nettype none
interface flash_bus_if;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic address_valid_n;
    logic [23:0] addr;
    logic [15:0] dq_host;
    logic dq_host_oe;
    logic [15:0] dq_dev;
    logic dq_dev_oe;
    logic [15:0] dq;
    assign dq = dq_dev_oe ? dq_dev : (dq_host_oe ? dq_host : 16'h0000);
    modport device (input ce_n, oe_n, we_n, address_valid_n, addr,
        dq, output dq_dev, dq_dev_oe);
    modport host (output ce_n, oe_n, we_n, address_valid_n, addr,
        dq_host, dq_host_oe, input dq);
endinterface
`default_nettype wire

// File: rtl/flash_cmd_cfg.svh
/*
 * Command codes, status bit positions and sizes for the flash command
 * decoder and its host-side sequencer. Included by the package and both ends.
 */
`ifndef FLASH_CMD_CFG_SVH
`define FLASH_CMD_CFG_SVH
`define CMD_LOCK_SETUP 8'h60
`define CMD_LOCK 8'h01
`define CMD_UNLOCK 8'hd0
`define CMD_LOCKDOWN 8'h2f
`define CMD_PROT_SETUP 8'hc0
`define CMD_RCFG_CONFIRM 8'h03
`define CMD_READ_STATUS 8'h70
`define CMD_CLEAR_STATUS 8'h50
`define CMD_READ_ARRAY 8'hff
`define CMD_PROG_SETUP 8'h40
`define CMD_ERASE_SETUP 8'h20
`define CMD_CONFIRM 8'hd0
`define CMD_SUSPEND 8'hb0
`define CMD_FACTORY_BULK_PROGRAMMING_SETUP 8'h80
`define SR_READY 7
`define SR_ESUSP 6
`define SR_EFAIL 5
`define SR_PFAIL 4
`define SR_VPPLOW 3
`define SR_PSUSP 2
`define SR_LOCKED 1
`define SR_FACTORY_BULK_PROGRAMMING 0
`define SR_RESET 8'h80
`define BLOCK_BITS 4
`define NUM_BLOCKS 16
`define BLOCK_LSB 16
`define RCFG_RESET 16'hbfcf
`define OP_CYCLES 8'h10
`define HREG_CMD 2'h0
`define HREG_ADDR 2'h1
`define HREG_DATA 2'h2
`define HREG_STAT 2'h3
`define HCMD_RD_BIT 16
`define HCMD_DATA_BIT 17
`endif

// File: rtl/flash_cmd_device.sv
/*
 * Device end: command decoder, block lock table, read setup register and
 * operation status. The array and its algorithms are modelled by a timer.
 * Assumes bus strobes are synchronous to i_clk and one write per we_n low.
 */
// Design decisions made here: strobed register access and the placing of the registers.
`default_nettype none
`include "flash_cmd_cfg.svh"
module flash_cmd_device
    import flash_cmd_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Array side conditions
    input wire logic i_supply_low,
    input wire logic i_op_fail,
    // Observed state
    output logic [15:0] o_read_setup_register,
    output logic [`NUM_BLOCKS-1:0] o_locked,
    output logic [`NUM_BLOCKS-1:0] o_locked_down,
    output logic o_prot_write,
    output logic [23:0] o_prot_addr,
    output logic [15:0] o_prot_data,
    // Flash bus
    flash_bus_if.device bus
);
    typedef enum logic [6:0] {
        C_IDLE = 7'h01,
        C_LOCK = 7'h02,
        C_PROT = 7'h04,
        C_PROG = 7'h08,
        C_ERASE = 7'h10,
        C_FACTORY_BULK_PROGRAMMING = 7'h20,
        C_RCFG = 7'h40
    } cstate_e;
    typedef enum logic [2:0] {
        OP_NONE = 3'h1,
        OP_PROG = 3'h2,
        OP_ERASE = 3'h4
    } op_e;

    cstate_e cstate;
    read_mode_e rmode;
    op_e op;
    logic factory_bulk_programming;
    logic [7:0] timer;
    logic [7:0] operation_status;
    logic we_d, rd_d;
    logic [15:0] status_read_data;
    lock_state_e lock_tab [`NUM_BLOCKS];
    logic [15:0] dq_out;
    logic dq_oe;

    logic wr_evt, rd_start, busy, seq_err, blk_locked, op_start, op_done;
    logic [7:0] cmd;
    logic [`BLOCK_BITS-1:0] blk;

    function automatic logic [`BLOCK_BITS-1:0] block_of(
        input logic [23:0] a);
        block_of = a[`BLOCK_LSB +: `BLOCK_BITS];
    endfunction

    assign wr_evt = !bus.ce_n && !bus.we_n && we_d;
    assign rd_start = !bus.ce_n && !bus.oe_n && rd_d;
    assign cmd = bus.dq[7:0];
    assign blk = block_of(bus.addr);
    assign busy = op != OP_NONE;
    assign blk_locked = lock_tab[blk] != LOCK_OPEN;
    // A wrong second cycle of a lock, erase or factory bulk programming command is a sequence error
    assign seq_err = wr_evt && (
        (cstate == C_LOCK && cmd != `CMD_LOCK && cmd != `CMD_UNLOCK
            && cmd != `CMD_LOCKDOWN && cmd != `CMD_RCFG_CONFIRM)
        || ((cstate == C_ERASE || cstate == C_FACTORY_BULK_PROGRAMMING)
            && cmd != `CMD_CONFIRM));
    // Protection registers are outside the array, so no block lock
    assign op_start = wr_evt && !busy
        && (cstate == C_PROT || (!blk_locked && (cstate == C_PROG
            || (cstate == C_ERASE && cmd == `CMD_CONFIRM)
            || (cstate == C_FACTORY_BULK_PROGRAMMING && cmd == `CMD_CONFIRM))));
    assign op_done = busy && timer == 8'h00;

    assign bus.dq_dev = dq_out;
    assign bus.dq_dev_oe = dq_oe;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            we_d <= 1'b1;
            rd_d <= 1'b1;
        end else begin
            we_d <= bus.ce_n || bus.we_n;
            rd_d <= bus.ce_n || bus.oe_n || bus.address_valid_n;
        end
    end

    // Command decoder
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cstate <= C_IDLE;
            rmode <= READ_ARRAY;
        end else if (wr_evt) begin
            cstate <= C_IDLE;
            if (cstate != C_IDLE) begin
                rmode <= (cstate == C_LOCK
                    && cmd == `CMD_RCFG_CONFIRM) ? READ_ARRAY
                    : READ_STATUS;
            end else begin
                unique case (cmd)
                    // Both 0x60 setups share one state; confirm decides
                    `CMD_LOCK_SETUP: cstate <= C_LOCK;
                    `CMD_PROT_SETUP: cstate <= C_PROT;
                    `CMD_PROG_SETUP: cstate <= C_PROG;
                    `CMD_ERASE_SETUP: cstate <= C_ERASE;
                    `CMD_FACTORY_BULK_PROGRAMMING_SETUP: cstate <= C_FACTORY_BULK_PROGRAMMING;
                    `CMD_READ_STATUS: rmode <= READ_STATUS;
                    `CMD_READ_ARRAY: rmode <= READ_ARRAY;
                    default: cstate <= C_IDLE;
                endcase
            end
        end
    end

    // A lock-setup followed by 0x03 is the read setup confirm
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_read_setup_register <= `RCFG_RESET;
        end else if (wr_evt && cstate == C_LOCK
            && cmd == `CMD_RCFG_CONFIRM) begin
            o_read_setup_register <= bus.addr[15:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            for (int i = 0; i < `NUM_BLOCKS; i++) begin
                lock_tab[i] <= LOCK_SET;
            end
        end else if (wr_evt && cstate == C_LOCK) begin
            if (cmd == `CMD_LOCK && lock_tab[blk] != LOCK_DOWN) begin
                lock_tab[blk] <= LOCK_SET;
            end else if (cmd == `CMD_UNLOCK
                && lock_tab[blk] != LOCK_DOWN) begin
                lock_tab[blk] <= LOCK_OPEN;
            end else if (cmd == `CMD_LOCKDOWN) begin
                lock_tab[blk] <= LOCK_DOWN;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_locked <= '0;
            o_locked_down <= '0;
        end else begin
            for (int i = 0; i < `NUM_BLOCKS; i++) begin
                o_locked[i] <= lock_tab[i] != LOCK_OPEN;
                o_locked_down[i] <= lock_tab[i] == LOCK_DOWN;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_prot_write <= 1'b0;
            o_prot_addr <= 24'h000000;
            o_prot_data <= 16'h0000;
        end else begin
            o_prot_write <= wr_evt && cstate == C_PROT;
            if (wr_evt && cstate == C_PROT) begin
                o_prot_addr <= bus.addr;
                o_prot_data <= bus.dq;
            end
        end
    end

    // Modelled program or erase timer
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            op <= OP_NONE;
            factory_bulk_programming <= 1'b0;
            timer <= 8'h00;
        end else if (op_start) begin
            op <= (cstate == C_ERASE) ? OP_ERASE : OP_PROG;
            factory_bulk_programming <= cstate == C_FACTORY_BULK_PROGRAMMING;
            timer <= `OP_CYCLES;
        end else if (op_done) begin
            op <= OP_NONE;
            factory_bulk_programming <= 1'b0;
        end else if (busy) begin
            timer <= timer - 8'h01;
        end
    end

    // Status: sticky error bits, hardware wins over a clear in one cycle
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            operation_status <= `SR_RESET;
        end else begin
            operation_status[`SR_READY] <= !busy || op_done;
            operation_status[`SR_ESUSP] <= 1'b0;
            operation_status[`SR_PSUSP] <= 1'b0;
            operation_status[`SR_FACTORY_BULK_PROGRAMMING] <= factory_bulk_programming && !op_done;
            if (wr_evt && cstate == C_IDLE
                && cmd == `CMD_CLEAR_STATUS) begin
                operation_status[`SR_EFAIL] <= 1'b0;
                operation_status[`SR_PFAIL] <= 1'b0;
                operation_status[`SR_VPPLOW] <= 1'b0;
                operation_status[`SR_LOCKED] <= 1'b0;
            end
            if (seq_err) begin
                operation_status[`SR_EFAIL] <= 1'b1;
                operation_status[`SR_PFAIL] <= 1'b1;
            end
            if (op_done && i_op_fail) begin
                if (op == OP_ERASE) begin
                    operation_status[`SR_EFAIL] <= 1'b1;
                end else begin
                    operation_status[`SR_PFAIL] <= 1'b1;
                end
            end
            if (busy && i_supply_low) begin
                operation_status[`SR_VPPLOW] <= 1'b1;
            end
            if (wr_evt && !busy && blk_locked && (cstate == C_PROG
                || ((cstate == C_ERASE || cstate == C_FACTORY_BULK_PROGRAMMING)
                    && cmd == `CMD_CONFIRM))) begin
                operation_status[`SR_LOCKED] <= 1'b1;
            end
        end
    end

    // Read output; status snapshot taken at start of each read
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            status_read_data <= 16'h0000;
            dq_out <= 16'h0000;
            dq_oe <= 1'b0;
        end else begin
            if (rd_start) begin
                status_read_data <= {8'h00, operation_status};
            end
            dq_oe <= !bus.ce_n && !bus.oe_n;
            if (rmode == READ_STATUS) begin
                dq_out <= rd_start ? {8'h00, operation_status}
                    : status_read_data;
            end else begin
                dq_out <= {bus.addr[15:0]};
            end
        end
    end
endmodule
`default_nettype wire

// File: rtl/flash_cmd_host.sv
/*
 * Host end: turns software register writes into flash bus cycles.
 * Assumes software waits for idle before the next command.
 * Each bus write takes one clock, each bus read two.
 */
`default_nettype none
`include "flash_cmd_cfg.svh"
module flash_cmd_host
    import flash_cmd_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Software port
    input wire logic [1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // Flash bus
    flash_bus_if.host bus
);
    typedef enum logic [3:0] {
        H_IDLE = 4'h1,
        H_WR = 4'h2,
        H_RD = 4'h4,
        H_RD2 = 4'h8
    } hstate_e;
    hstate_e state;
    logic [23:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic ce_n, oe_n, we_n, adv_n, dq_oe;
    logic [23:0] a_out;
    logic [15:0] d_out;

    assign bus.ce_n = ce_n;
    assign bus.oe_n = oe_n;
    assign bus.we_n = we_n;
    assign bus.address_valid_n = adv_n;
    assign bus.addr = a_out;
    assign bus.dq_host = d_out;
    assign bus.dq_host_oe = dq_oe;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            addr <= 24'h000000;
            wdata <= 16'h0000;
        end else if (i_wr && i_addr == `HREG_ADDR) begin
            addr <= i_wdata[23:0];
        end else if (i_wr && i_addr == `HREG_DATA) begin
            wdata <= i_wdata[15:0];
        end
    end

    // Writing CMD issues one bus write; bit 16 asks for a read instead
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state <= H_IDLE;
            ce_n <= 1'b1;
            oe_n <= 1'b1;
            we_n <= 1'b1;
            adv_n <= 1'b1;
            dq_oe <= 1'b0;
            a_out <= 24'h000000;
            d_out <= 16'h0000;
            rdata <= 16'h0000;
        end else begin
            unique case (state)
                H_IDLE: begin
                    if (i_wr && i_addr == `HREG_CMD) begin
                        a_out <= addr;
                        ce_n <= 1'b0;
                        adv_n <= 1'b0;
                        if (i_wdata[`HCMD_RD_BIT]) begin
                            oe_n <= 1'b0;
                            state <= H_RD;
                        end else begin
                            we_n <= 1'b0;
                            dq_oe <= 1'b1;
                            d_out <= (i_wdata[`HCMD_DATA_BIT]) ? wdata
                                : {8'h00, i_wdata[7:0]};
                            state <= H_WR;
                        end
                    end
                end
                H_WR: begin
                    // Separate edges keep each cycle of a pair distinct
                    ce_n <= 1'b1;
                    we_n <= 1'b1;
                    adv_n <= 1'b1;
                    dq_oe <= 1'b0;
                    state <= H_IDLE;
                end
                H_RD: begin
                    state <= H_RD2;
                end
                H_RD2: begin
                    rdata <= bus.dq;
                    ce_n <= 1'b1;
                    oe_n <= 1'b1;
                    adv_n <= 1'b1;
                    state <= H_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rdata <= 32'h00000000;
        end else if (i_rd) begin
            unique case (i_addr)
                `HREG_CMD: o_rdata <= {31'h00000000, state != H_IDLE};
                `HREG_ADDR: o_rdata <= {8'h00, addr};
                `HREG_DATA: o_rdata <= {16'h0000, wdata};
                `HREG_STAT: o_rdata <= {16'h0000, rdata};
            endcase
        end else begin
            o_rdata <= 32'h00000000;
        end
    end
endmodule
`default_nettype wire

// File: rtl/flash_cmd_pkg.sv
/*
 * Shared types for the flash command link.
 * Assumes flash_cmd_cfg.svh is on the include path.
 */
`default_nettype none
`include "flash_cmd_cfg.svh"
package flash_cmd_pkg;
    typedef enum logic [1:0] {
        LOCK_OPEN = 2'h0,
        LOCK_SET = 2'h1,
        LOCK_DOWN = 2'h3
    } lock_state_e;
    typedef enum logic [1:0] {
        READ_ARRAY = 2'h1,
        READ_STATUS = 2'h2
    } read_mode_e;
endpackage
`default_nettype wire

// File: sim/flash_cmd_chk.sv
/*
 * Checker for the flash bus between host sequencer and command decoder.
 * Assumes one clock and that only suspend-free traffic is sent.
 */
`default_nettype none
module flash_cmd_chk (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Flash bus
    input wire logic ce_n,
    input wire logic we_n,
    input wire logic [23:0] addr,
    input wire logic [15:0] dq,
    input wire logic [15:0] dq_dev,
    input wire logic dq_dev_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    logic prev_w, pend, smode, err, factory_bulk_programming, take, rd_s;
    logic [7:0] first;
    logic [7:0] d;
    logic [4:0] busy;
    assign d = dq[7:0];
    assign take = !ce_n && !we_n && prev_w;
    assign rd_s = dq_dev_oe && smode;
    always_ff @(posedge i_clk) begin
        prev_w <= i_rst | ce_n | we_n;
    end
    // Shadow of the decoder: pairing, read mode, error and busy window
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pend <= 1'b0;
            smode <= 1'b0;
            err <= 1'b0;
            factory_bulk_programming <= 1'b0;
            busy <= 5'h00;
            first <= 8'h00;
        end else begin
            if (busy != 5'h00) begin
                busy <= busy - 5'h01;
            end
            if (take && pend) begin
                pend <= 1'b0;
                smode <= !(first == 8'h60 && d == 8'h03);
                if (first == 8'h60 && !(d inside {8'h01, 8'hd0, 8'h2f,
                        8'h03})) begin
                    err <= 1'b1;
                end
                if (first == 8'hc0 || first == 8'h80) begin
                    busy <= 5'h10;
                    factory_bulk_programming <= (first == 8'h80);
                end
            end else if (take) begin
                pend <= d inside {8'h60, 8'hc0, 8'h40, 8'h20, 8'h80};
                first <= d;
                if (d == 8'h70) begin
                    smode <= 1'b1;
                end
                if (d == 8'hff) begin
                    smode <= 1'b0;
                end
                if (d == 8'h50) begin
                    err <= 1'b0;
                end
            end
        end
    end
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    sequence held_read;
        dq_dev_oe ##1 dq_dev_oe;
    endsequence
    hi_byte_zero_a: assert property (rd_s |-> dq_dev[15:8] == 8'h00)
        else $error("status read upper byte not zero");
    seq_error_a: assert property (rd_s && err |-> dq_dev[7:4] == 4'hb)
        else $error("sequence error bits missing");
    array_read_a: assert property (dq_dev_oe && !smode |->
        dq_dev == addr[15:0])
        else $error("array read shows wrong data");
    busy_low_a: assert property (busy > 5'h04 && rd_s |-> !dq_dev[7])
        else $error("ready bit high during operation");
    factory_bulk_programming_busy_a: assert property (busy > 5'h04 && factory_bulk_programming && rd_s |->
        dq_dev[0])
        else $error("factory busy bit low during operation");
    erase_susp_a: assert property (rd_s |-> !dq_dev[6])
        else $error("erase suspend bit set without suspend");
    prog_susp_a: assert property (rd_s |-> !dq_dev[2])
        else $error("program suspend bit set without suspend");
    snapshot_a: assert property (held_read |-> $stable(dq_dev))
        else $error("read data changed within one read");
endmodule
`default_nettype wire

// File: sim/flash_command_status_lock_tb.sv
/*
 * Testbench: host and device joined by the flash bus, driven by software
 * port calls. Assumes the package and the include path of rtl/.
 */
`default_nettype none
`include "flash_cmd_cfg.svh"
module flash_command_status_lock_tb
    import flash_cmd_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_clk = 1'b0;
    logic i_rst, i_wr, i_rd, i_supply_low, i_op_fail;
    logic [1:0] i_addr;
    logic [31:0] i_wdata, o_rdata;
    logic [15:0] o_read_setup_register, o_locked, o_locked_down;
    logic o_prot_write;
    logic [23:0] o_prot_addr;
    logic [15:0] o_prot_data, v, pw_cnt, pa, pd;
    int error_cnt = 0;
    int num_checks = 0;
    always #12.5 i_clk = ~i_clk;
    flash_bus_if bus_if ();
    flash_cmd_host u_flash_cmd_host (.i_clk(i_clk), .i_rst(i_rst),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .bus(bus_if));
    flash_cmd_device u_flash_cmd_device (.i_clk(i_clk), .i_rst(i_rst),
        .i_supply_low(i_supply_low), .i_op_fail(i_op_fail),
        .o_read_setup_register(o_read_setup_register),
        .o_locked(o_locked), .o_locked_down(o_locked_down),
        .o_prot_write(o_prot_write), .o_prot_addr(o_prot_addr),
        .o_prot_data(o_prot_data), .bus(bus_if));
    flash_cmd_chk u_flash_cmd_chk (.i_clk(i_clk), .i_rst(i_rst),
        .ce_n(bus_if.ce_n), .we_n(bus_if.we_n), .addr(bus_if.addr),
        .dq(bus_if.dq), .dq_dev(bus_if.dq_dev),
        .dq_dev_oe(bus_if.dq_dev_oe));
    // Capture of protection writes
    always @(posedge i_clk) begin
        if (o_prot_write === 1'b1) begin
            pw_cnt = pw_cnt + 16'h0001;
            pa = o_prot_addr[15:0];
            pd = o_prot_data;
        end
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic sw_wr(input logic [1:0] a, input logic [31:0] w);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= w;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic sw_rd(input logic [1:0] a, output logic [31:0] r);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        r = o_rdata;
    endtask
    task automatic wait_idle();
        logic [31:0] r;
        int n;
        n = 0;
        r = 32'h1;
        while (r[0] !== 1'b0 && n < 40) begin
            sw_rd(`HREG_CMD, r);
            n++;
        end
        check(r[15:0] & 16'h0001, 16'h0000);
    endtask
    task automatic cmd(input logic [23:0] a, input logic [7:0] c);
        sw_wr(`HREG_ADDR, {8'h00, a});
        sw_wr(`HREG_CMD, {24'h000000, c});
        wait_idle();
    endtask
    task automatic dwr(input logic [23:0] a, input logic [15:0] w);
        sw_wr(`HREG_ADDR, {8'h00, a});
        sw_wr(`HREG_DATA, {16'h0000, w});
        sw_wr(`HREG_CMD, 32'h00020000);
        wait_idle();
    endtask
    task automatic rd(input logic [23:0] a, output logic [15:0] r16);
        logic [31:0] r;
        sw_wr(`HREG_ADDR, {8'h00, a});
        sw_wr(`HREG_CMD, 32'h00010000);
        wait_idle();
        sw_rd(`HREG_STAT, r);
        r16 = r[15:0];
    endtask
    task automatic stat(input logic [15:0] exp);
        logic [15:0] r16;
        rd(24'h0abcde, r16);
        check(r16, exp);
    endtask
    task automatic lk(input logic [3:0] b, input logic [7:0] c);
        cmd({4'h0, b, 16'h5a5a}, `CMD_LOCK_SETUP);
        cmd({4'h0, b, 16'h5a5a}, c);
    endtask
    task automatic clr();
        cmd(24'h000000, `CMD_CLEAR_STATUS);
        cmd(24'h000000, `CMD_READ_STATUS);
    endtask
    task automatic op_wait();
        repeat (`OP_CYCLES + 8'h08) @(posedge i_clk);
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge i_clk);
        error_cnt++;
        finish_test();
    end
    initial begin
        {i_rst, i_wr, i_rd, i_supply_low, i_op_fail} = 5'b10000;
        i_addr = 2'h0;
        i_wdata = 32'h0;
        pw_cnt = 16'h0;
        repeat (12) @(posedge i_clk);
        i_rst <= 1'b0;
        rd(24'h000123, v);
        check(v, 16'h0123);
        cmd(24'h0abcde, `CMD_READ_STATUS);
        stat(16'h0080);
        lk(4'h2, `CMD_UNLOCK);
        lk(4'h3, `CMD_UNLOCK);
        check({14'h0, o_locked[3:2]}, 16'h0000);
        stat(16'h0080);
        lk(4'h3, `CMD_LOCK);
        check({15'h0, o_locked[3]}, 16'h0001);
        lk(4'h5, `CMD_LOCKDOWN);
        check({15'h0, o_locked_down[5]}, 16'h0001);
        lk(4'h5, `CMD_UNLOCK);
        check({15'h0, o_locked[5]}, 16'h0001);
        lk(4'h1, `CMD_READ_STATUS);
        stat(16'h00b0);
        clr();
        stat(16'h0080);
        lk(4'h1, `CMD_ERASE_SETUP);
        cmd(24'h0, `CMD_READ_STATUS);
        stat(16'h00b0);
        clr();
        cmd(24'h001234, `CMD_LOCK_SETUP);
        cmd(24'h001234, `CMD_RCFG_CONFIRM);
        check(o_read_setup_register, 16'h1234);
        rd(24'h000777, v);
        check(v, 16'h0777);
        cmd(24'h0, `CMD_PROT_SETUP);
        dwr(24'h000089, 16'hbeef);
        rd(24'h0, v);
        check(v & 16'h0080, 16'h0000);
        op_wait();
        check(pw_cnt, 16'h0001);
        check(pa, 16'h0089);
        check(pd, 16'hbeef);
        stat(16'h0080);
        cmd(24'h0, `CMD_PROG_SETUP);
        dwr(24'h0, 16'h1111);
        op_wait();
        stat(16'h0082);
        clr();
        @(posedge i_clk);
        i_supply_low <= 1'b1;
        cmd(24'h020000, `CMD_PROG_SETUP);
        dwr(24'h020000, 16'h2222);
        op_wait();
        i_supply_low <= 1'b0;
        stat(16'h0088);
        clr();
        @(posedge i_clk);
        i_op_fail <= 1'b1;
        cmd(24'h020000, `CMD_PROG_SETUP);
        dwr(24'h020000, 16'h3333);
        op_wait();
        stat(16'h0090);
        clr();
        cmd(24'h020000, `CMD_ERASE_SETUP);
        cmd(24'h020000, `CMD_CONFIRM);
        op_wait();
        i_op_fail <= 1'b0;
        stat(16'h00a0);
        clr();
        cmd(24'h020000, `CMD_FACTORY_BULK_PROGRAMMING_SETUP);
        cmd(24'h020000, `CMD_CONFIRM);
        rd(24'h0, v);
        check(v & 16'h0081, 16'h0001);
        op_wait();
        stat(16'h0080);
        cmd(24'h0, `CMD_READ_ARRAY);
        rd(24'h004321, v);
        check(v, 16'h4321);
        lk(4'h1, `CMD_READ_STATUS);
        @(posedge i_clk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        cmd(24'h0, `CMD_READ_STATUS);
        stat(16'h0080);
        finish_test();
    end
endmodule
`default_nettype wire
